// File: design/tec_top.sv
// Trigger engine control: command decode, arming, force, delay and holdoff.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns

// How it works
// - Software source fires at once when armed
// - Force fires only while waiting for trigger
// - One force command gives one event
// - After force, resume normal trigger waiting
// - Command register is write only
// - Arm command enables trigger recognition
// - Disarm blocks all events except force
// - Engine comes out of reset disarmed
// - Delay is last stage, source independent
// - Delay acts on already combined event
// - Delay counted in clocks, zero adds none
// - Delay accepts full 32-bit range
// - Read-only register reports maximum delay
// - Delay shifts event, not sample counts
// - Holdoff only in segmented modes
// - Dead time after post area drops triggers
// - Holdoff in clocks, zero disables it
// - Holdoff accepts full 32-bit range
// - Read-only register reports maximum holdoff
module tec_top #(
   parameter int CNT_W = 32
) (
   // Clock, reset and enable
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       ce,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [tec_pkg::ADDR_W-1:0] paddr,
   input  wire logic [tec_pkg::DATA_W-1:0] pwdata,
   output logic      [tec_pkg::DATA_W-1:0] prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Card sequencer
   input  wire logic                       card_run,
   input  wire logic                       post_done,
   // Combined external trigger pin
   input  wire logic                       ext_trig_pin,
   // Trigger and status
   output logic                            trig_out,
   output logic                            armed,
   output logic                            waiting,
   output logic                            holdoff_active
);
   import tec_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] or_mask_q;
   logic [CNT_W-1:0]  delay_value_q;
   logic [CNT_W-1:0]  holdoff_value_q;
   logic              segmented_q;
   logic              armed_q;
   tec_state_t        state_q;
   tec_state_t        state_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic              ext_level;
   logic              ext_level_q;
   logic              ext_edge;
   logic              setup;
   logic              wr_en;
   logic              cmd_wr;
   logic              force_cmd;
   logic              arm_cmd;
   logic              disarm_cmd;
   logic              src_event;
   logic              accept;
   logic              fire;
   logic              addr_hit;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] status_word;

   // ------------------------------------------------------------------
   // External trigger synchroniser
   // ------------------------------------------------------------------
   tec_sync u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .async_in  (ext_trig_pin),
      .level_out (ext_level)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_level_q <= 1'b0;
      end else if (ce) begin
         ext_level_q <= ext_level;
      end
   end

   assign ext_edge = ext_level & ~ext_level_q;

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   // Writes land on the edge that completes the access phase; the slave
   // answers with no wait state, pready rising in the first access cycle.
   assign setup  = psel & ~penable;
   assign wr_en  = psel & penable & pready & pwrite;
   assign cmd_wr = wr_en && (paddr == tec_reg_addr(IDX_CARD_COMMAND));

   // Disarm takes precedence when both codes are written together.
   assign arm_cmd    = cmd_wr && ((pwdata & ARM_ENGINE_CMD) != '0)
                       && ((pwdata & DISARM_ENGINE_CMD) == '0);
   assign disarm_cmd = cmd_wr && ((pwdata & DISARM_ENGINE_CMD) != '0);
   assign force_cmd  = cmd_wr && ((pwdata & FORCE_TRIGGER_CMD) != '0);

   always_comb begin
      status_word = '0;
      status_word[STAT_ARMED_BIT]   = armed_q;
      status_word[STAT_WAITING_BIT] = (state_q == TEC_WAIT);
      status_word[STAT_DELAY_BIT]   = (state_q == TEC_DELAY);
      status_word[STAT_HOLDOFF_BIT] = (state_q == TEC_HOLDOFF);
      status_word[STAT_STATE_LSB +: $bits(tec_state_t)] = state_q;
   end

   always_comb begin
      addr_hit = 1'b1;
      rd_data  = '0;
      case (paddr)
         tec_reg_addr(IDX_CARD_COMMAND): begin
            rd_data = '0;
         end
         tec_reg_addr(IDX_OR_MASK): begin
            rd_data = or_mask_q;
         end
         tec_reg_addr(IDX_MAX_DELAY): begin
            rd_data = MAX_DELAY_VALUE;
         end
         tec_reg_addr(IDX_MAX_HOLDOFF): begin
            rd_data = MAX_HOLDOFF_VALUE;
         end
         tec_reg_addr(IDX_DELAY_VALUE): begin
            rd_data[CNT_W-1:0] = delay_value_q;
         end
         tec_reg_addr(IDX_HOLDOFF_VALUE): begin
            rd_data[CNT_W-1:0] = holdoff_value_q;
         end
         tec_reg_addr(IDX_ENGINE_CTRL): begin
            rd_data[CTRL_SEGMENTED_BIT] = segmented_q;
         end
         tec_reg_addr(IDX_ENGINE_STATUS): begin
            rd_data = status_word;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= setup;
         prdata  <= (setup && !pwrite) ? rd_data : '0;
         pslverr <= setup && !addr_hit;
      end
   end

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         or_mask_q       <= OR_MASK_RESET;
         delay_value_q   <= '0;
         holdoff_value_q <= '0;
         segmented_q     <= 1'b0;
      end else if (ce && wr_en) begin
         if (paddr == tec_reg_addr(IDX_OR_MASK)) begin
            or_mask_q <= pwdata & OR_MASK_USED;
         end
         if (paddr == tec_reg_addr(IDX_DELAY_VALUE)) begin
            delay_value_q <= pwdata[CNT_W-1:0];
         end
         if (paddr == tec_reg_addr(IDX_HOLDOFF_VALUE)) begin
            holdoff_value_q <= pwdata[CNT_W-1:0];
         end
         if (paddr == tec_reg_addr(IDX_ENGINE_CTRL)) begin
            segmented_q <= pwdata[CTRL_SEGMENTED_BIT];
         end
      end
   end

   // ------------------------------------------------------------------
   // Arming
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
      end else if (ce) begin
         if (disarm_cmd) begin
            armed_q <= 1'b0;
         end else if (arm_cmd) begin
            armed_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Trigger acceptance
   // ------------------------------------------------------------------
   // software free run
   assign src_event = armed_q && (or_mask_q[SOFTWARE_SOURCE_BIT]
                      || (or_mask_q[EXT_SOURCE_BIT] && ext_edge));

   assign accept = (state_q == TEC_WAIT) && (src_event || force_cmd);

   // one delay path for all sources
   assign fire = (accept && (delay_value_q == '0))
                 || ((state_q == TEC_DELAY) && (cnt_q == CNT_W'(1)));

   // ------------------------------------------------------------------
   // Engine state machine
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         TEC_IDLE: begin
            if (card_run) begin
               state_d = TEC_WAIT;
            end
         end
         TEC_WAIT: begin
            if (!card_run) begin
               state_d = TEC_IDLE;
            end else if (fire) begin
               state_d = TEC_CAPTURE;
            end else if (accept) begin
               state_d = TEC_DELAY;
               cnt_d   = delay_value_q;
            end
         end
         TEC_DELAY: begin
            if (!card_run) begin
               state_d = TEC_IDLE;
            end else if (fire) begin
               state_d = TEC_CAPTURE;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         TEC_CAPTURE: begin
            if (!card_run) begin
               state_d = TEC_IDLE;
            end else if (post_done) begin
               if (!segmented_q) begin
                  state_d = TEC_DONE;
               end else if (holdoff_value_q != '0) begin
                  state_d = TEC_HOLDOFF;
                  cnt_d   = holdoff_value_q;
               end else begin
                  state_d = TEC_WAIT;
               end
            end
         end
         TEC_HOLDOFF: begin
            if (!card_run) begin
               state_d = TEC_IDLE;
            end else if (cnt_q == CNT_W'(1)) begin
               state_d = TEC_WAIT;
               cnt_d   = '0;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         TEC_DONE: begin
            if (!card_run) begin
               state_d = TEC_IDLE;
            end
         end
         default: begin
            state_d = TEC_IDLE;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= TEC_IDLE;
         cnt_q   <= '0;
      end else if (ce) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   // The trigger pulse only marks the moment; pre and post sample counts
   // belong to the sequencer and are not touched here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_out       <= 1'b0;
         armed          <= 1'b0;
         waiting        <= 1'b0;
         holdoff_active <= 1'b0;
      end else if (ce) begin
         trig_out       <= fire && card_run;
         armed          <= (armed_q || arm_cmd) && !disarm_cmd;
         waiting        <= (state_d == TEC_WAIT);
         holdoff_active <= (state_d == TEC_HOLDOFF);
      end
   end

endmodule

// File: design/tec_pkg.sv
// Package with register map, command codes and states of the trigger engine control.
package tec_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ------------------------------------------------------------------
   localparam logic [15:0] IDX_CARD_COMMAND   = 16'h0064;
   localparam logic [15:0] IDX_OR_MASK        = 16'h9dda;
   localparam logic [15:0] IDX_MAX_DELAY      = 16'h9f60;
   localparam logic [15:0] IDX_MAX_HOLDOFF    = 16'h9f62;
   localparam logic [15:0] IDX_DELAY_VALUE    = 16'h9f6a;
   localparam logic [15:0] IDX_HOLDOFF_VALUE  = 16'h9f6b;
   localparam logic [15:0] IDX_ENGINE_CTRL    = 16'h9f70;
   localparam logic [15:0] IDX_ENGINE_STATUS  = 16'h9f71;

   // ------------------------------------------------------------------
   // Command codes written to the card command register
   // ------------------------------------------------------------------
   localparam logic [31:0] ARM_ENGINE_CMD    = 32'h0000_0008;
   localparam logic [31:0] FORCE_TRIGGER_CMD = 32'h0000_0010;
   localparam logic [31:0] DISARM_ENGINE_CMD = 32'h0000_0020;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int SOFTWARE_SOURCE_BIT = 0;
   localparam int EXT_SOURCE_BIT      = 1;
   localparam logic [31:0] OR_MASK_RESET = 32'h0000_0001;
   localparam logic [31:0] OR_MASK_USED  = 32'h0000_0003;
   localparam int CTRL_SEGMENTED_BIT  = 0;
   localparam int STAT_ARMED_BIT      = 0;
   localparam int STAT_WAITING_BIT    = 1;
   localparam int STAT_DELAY_BIT      = 2;
   localparam int STAT_HOLDOFF_BIT    = 3;
   localparam int STAT_STATE_LSB      = 4;
   localparam logic [31:0] MAX_DELAY_VALUE   = 32'hffff_ffff;
   localparam logic [31:0] MAX_HOLDOFF_VALUE = 32'hffff_ffff;

   // ------------------------------------------------------------------
   // Engine states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      TEC_IDLE    = 3'b000,
      TEC_WAIT    = 3'b001,
      TEC_DELAY   = 3'b010,
      TEC_CAPTURE = 3'b011,
      TEC_HOLDOFF = 3'b100,
      TEC_DONE    = 3'b101
   } tec_state_t;

   function automatic logic [ADDR_W-1:0] tec_reg_addr(input logic [15:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

// File: design/tec_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous input.
`timescale 1ns/1ns
module tec_sync (
   // Clock, reset and enable
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   // Asynchronous input and filtered level
   input  wire logic async_in,
   output logic      level_out
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ------------------------------------------------------------------
   // Shift chain
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (ce) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ------------------------------------------------------------------
   // Filter
   // ------------------------------------------------------------------
   // A change is taken only when the second and third stage agree, so a
   // single metastable sample never reaches the edge detector.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_out <= 1'b0;
      end else if (ce && (s2_q == s3_q)) begin
         level_out <= s3_q;
      end
   end

endmodule

// File: verification/tec_monitor.sv
// Concurrent checker of the trigger engine control ports.
`timescale 1ns/1ns
module tec_monitor #(
   parameter int CNT_W = 32
) (
   // Clock, reset and enable
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       ce,
   // APB slave
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [tec_pkg::ADDR_W-1:0] paddr,
   input wire logic [tec_pkg::DATA_W-1:0] pwdata,
   input wire logic [tec_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   // Sequencer and trigger pin
   input wire logic                       card_run,
   input wire logic                       post_done,
   input wire logic                       ext_trig_pin,
   // Trigger and status
   input wire logic                       trig_out,
   input wire logic                       armed,
   input wire logic                       waiting,
   input wire logic                       holdoff_active
);
   import tec_pkg::*;

   // ---------------------------------------------------------------
   // Shadow of the programmed counts
   // ---------------------------------------------------------------
   logic        wr_ok;
   logic        cmd_wr;
   logic [31:0] dly_q;
   logic [31:0] hold_q;
   logic [31:0] hcnt_q;

   assign wr_ok  = psel && penable && pready && pwrite && ce;
   assign cmd_wr = wr_ok && paddr == {IDX_CARD_COMMAND, 2'b00};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_q <= 32'h0000_0000;
      end else if (wr_ok && paddr == {IDX_DELAY_VALUE, 2'b00}) begin
         dly_q <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 32'h0000_0000;
      end else if (wr_ok && paddr == {IDX_HOLDOFF_VALUE, 2'b00}) begin
         hold_q <= pwdata;
      end
   end

   // Frozen edges are skipped, since a stalled clock must not lengthen the count.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt_q <= 32'h0000_0000;
      end else if (!holdoff_active) begin
         hcnt_q <= 32'h0000_0000;
      end else if (ce) begin
         hcnt_q <= hcnt_q + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready && ce |=> !pready)
      else $error("pready longer than one cycle");
   a_cmd_reads_zero: assert property (
      pready && psel && !pwrite && paddr == {IDX_CARD_COMMAND, 2'b00} |-> prdata == 32'h0)
      else $error("command register read not zero");
   a_max_delay_read: assert property (
      pready && psel && !pwrite && paddr == {IDX_MAX_DELAY, 2'b00} |-> prdata == 32'hffff_ffff)
      else $error("maximum delay value wrong");
   a_arm_needs_cmd: assert property (
      $rose(armed) |-> $past(cmd_wr && pwdata[3] && !pwdata[5]))
      else $error("engine armed without command");
   a_disarm_clears: assert property (cmd_wr && pwdata[5] |=> !armed)
      else $error("disarm command ignored");
   a_force_fires: assert property (
      cmd_wr && pwdata[4] && waiting && card_run && dly_q == 32'h0 |=> trig_out)
      else $error("forced trigger missing");
   a_trig_single: assert property (trig_out && ce |=> !trig_out)
      else $error("trigger pulse too long");
   a_no_trig_holdoff: assert property (holdoff_active |=> !trig_out)
      else $error("trigger during dead time");
   a_holdoff_length: assert property ($fell(holdoff_active) |-> hcnt_q == hold_q)
      else $error("dead time length wrong");
   a_zero_holdoff: assert property (
      post_done && hold_q == 32'h0 && !holdoff_active |-> ##1 !holdoff_active [*2])
      else $error("dead time with zero holdoff");

   c_force_disarmed: cover property (trig_out && !armed);
   c_armed_trig: cover property (trig_out && armed);
   c_holdoff: cover property (holdoff_active);
   c_slave_err: cover property (pslverr);
endmodule

bind tec_top tec_monitor #(.CNT_W(CNT_W)) u_mon (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .card_run(card_run), .post_done(post_done),
   .ext_trig_pin(ext_trig_pin), .trig_out(trig_out), .armed(armed),
   .waiting(waiting), .holdoff_active(holdoff_active)
);

// File: verification/trigger_engine_control_test.sv
// Self-checking testbench of the trigger engine control.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module trigger_engine_control_test;
   import tec_pkg::*;
   logic              pclk, presetn, ce, psel, penable, pwrite;
   logic              card_run, post_done, ext_trig_pin;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic              pready, pslverr, trig_out, armed, waiting, holdoff_active, er;
   int                num_errors, n_tests, ntrig, n0, k, d, h, hc, seed;
   logic [15:0]       ro_idx [2] = '{IDX_MAX_DELAY, IDX_MAX_HOLDOFF};
   logic [15:0]       rw_idx [2] = '{IDX_DELAY_VALUE, IDX_HOLDOFF_VALUE};

   tec_top #(.CNT_W(32)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .card_run(card_run), .post_done(post_done),
      .ext_trig_pin(ext_trig_pin), .trig_out(trig_out), .armed(armed),
      .waiting(waiting), .holdoff_active(holdoff_active)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Counted on the falling edge so the count never races the stimulus.
   always @(negedge pclk) begin
      if (trig_out === 1'b1) ntrig++;
   end

   task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] v);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) num_errors++;
   endtask

   task automatic wait_trig();
      k = 0;
      do begin @(posedge pclk); k++; end while (trig_out !== 1'b1 && k < 40);
   endtask

   task automatic pulse_post();
      @(posedge pclk); post_done <= 1'b1;
      @(posedge pclk); post_done <= 1'b0;
   endtask

   task automatic count_holdoff(input int span);
      hc = 0;
      repeat (span) begin @(posedge pclk); if (holdoff_active === 1'b1) hc++; end
   endtask

   task summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      summarize();
   end

   initial begin
      seed = 32'hea9af264;
      {presetn, psel, penable, pwrite, card_run, post_done, ext_trig_pin} = 7'h00;
      ce = 1'b1; paddr = '0; pwdata = '0;
      num_errors = 0; n_tests = 0; ntrig = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK(armed, 1'b0)
      // ---------------------------------------------------------------
      // Register map
      // ---------------------------------------------------------------
      foreach (ro_idx[i]) begin
         apb(1'b1, ro_idx[i], 32'h0000_1234);
         apb(1'b0, ro_idx[i], 32'h0);
         `CHK(rd, 32'hffff_ffff)
      end
      foreach (rw_idx[i]) begin
         apb(1'b1, rw_idx[i], 32'hffff_ffff);
         apb(1'b0, rw_idx[i], 32'h0);
         `CHK(rd, 32'hffff_ffff)
         apb(1'b1, rw_idx[i], 32'h0000_0000);
      end
      apb(1'b0, IDX_CARD_COMMAND, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(1'b0, 16'h0001, 32'h0);
      `CHK({er, rd}, 33'h1_0000_0000)
      apb(1'b0, IDX_OR_MASK, 32'h0);
      `CHK(rd, 32'h0000_0001)
      // ---------------------------------------------------------------
      // Forced triggers with the engine disarmed
      // ---------------------------------------------------------------
      apb(1'b1, IDX_CARD_COMMAND, FORCE_TRIGGER_CMD);
      wait_trig();
      `CHK(k, 40)
      apb(1'b1, IDX_ENGINE_CTRL, 32'h0000_0001);
      card_run <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK({waiting, ntrig}, {1'b1, 32'd0})
      apb(1'b0, IDX_ENGINE_STATUS, 32'h0);
      `CHK(rd, 32'(1 << STAT_WAITING_BIT) | 32'(1 << STAT_STATE_LSB))
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 0 : ($random(seed) & 7);
         apb(1'b1, IDX_DELAY_VALUE, 32'(d));
         n0 = ntrig;
         apb(1'b1, IDX_CARD_COMMAND, FORCE_TRIGGER_CMD);
         wait_trig();
         `CHK(k, d + 1)
         repeat (10) @(posedge pclk);
         `CHK(ntrig, n0 + 1)
         pulse_post();
         count_holdoff(3);
         `CHK({hc, waiting}, {32'd0, 1'b1})
      end
      // ---------------------------------------------------------------
      // Armed software source, dead time in segmented mode
      // ---------------------------------------------------------------
      h = ($random(seed) & 7) + 1;
      apb(1'b1, IDX_HOLDOFF_VALUE, 32'(h));
      apb(1'b1, IDX_CARD_COMMAND, ARM_ENGINE_CMD);
      wait_trig();
      `CHK(k, d + 2)
      n0 = ntrig;
      pulse_post();
      count_holdoff(30);
      `CHK(hc, h)
      `CHK(ntrig, n0 + 1)
      apb(1'b1, IDX_ENGINE_CTRL, 32'h0000_0000);
      n0 = ntrig;
      pulse_post();
      count_holdoff(15);
      `CHK({hc, waiting, ntrig}, {32'd0, 1'b0, n0})
      card_run <= 1'b0;
      repeat (3) @(posedge pclk);
      card_run <= 1'b1;
      wait_trig();
      `CHK(k, d + 3)
      // ---------------------------------------------------------------
      // Disarmed engine ignores the pin, armed engine delays it alike
      // ---------------------------------------------------------------
      apb(1'b1, IDX_ENGINE_CTRL, 32'h0000_0001);
      apb(1'b1, IDX_HOLDOFF_VALUE, 32'h0000_0000);
      apb(1'b1, IDX_OR_MASK, 32'h0000_0002);
      apb(1'b1, IDX_CARD_COMMAND, DISARM_ENGINE_CMD | ARM_ENGINE_CMD);
      @(posedge pclk);
      `CHK(armed, 1'b0)
      pulse_post();
      n0 = ntrig;
      repeat (40) @(posedge pclk) ext_trig_pin <= 1'($random(seed));
      ext_trig_pin <= 1'b0;
      repeat (10) @(posedge pclk);
      `CHK({waiting, ntrig}, {1'b1, n0})
      apb(1'b1, IDX_CARD_COMMAND, ARM_ENGINE_CMD);
      ext_trig_pin <= 1'b1;
      wait_trig();
      `CHK(k > d && k <= d + 8, 1'b1)
      ext_trig_pin <= 1'b0;
      repeat (5) @(posedge pclk);
      summarize();
   end
endmodule
